// File: bench/ccr_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side: apb master that the bench steers through xfer
module ccr_host (
  // clock
  input wire logic CLOCK,
  // apb master
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [11:0] PADDR,
  output logic [31:0] PWDATA,
  output logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  logic [31:0] rdata;
  logic rerr;
  // idle bus at time zero
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    PSTRB = 4'hf;
  end
  // one transfer, held until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [7:0] data);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= {2'b00, idx, 2'b00};
    PWDATA <= {24'h0, data};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rdata = PRDATA;
    rerr = PSLVERR;
    // released data no longer shows the last value
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    PWDATA <= ~PWDATA;
  endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ccr_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h2a; // arbitrary value
  logic clock, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic pin, sleep_pin, rail_enable, sleep_active, irq_n;
  logic [7:0] v;
  ccr_fault_t faults;
  ccr_cfg_t cfg;
  int n_errors = 0;
  int n_tests = 0;
  ccr_host host_i (.CLOCK(clock), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  ccr_regs #(.STEP_CYCLES(4), .ID_DEVICE(ID_VAL[7]),
    .ID_FUSE(ID_VAL[6:2]), .ID_SILICON(ID_VAL[1:0])) ccr_regs_i (
    .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HW_RAIL_CONTROL_PIN(pin), .SLEEP_PIN(sleep_pin), .FAULTS(faults),
    .CFG(cfg), .RAIL_ENABLE(rail_enable), .SLEEP_ACTIVE(sleep_active),
    .IRQ_N(irq_n));
  // clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    host_i.xfer(1'b0, idx, 8'h00);
    chk("readback", host_i.rdata, {24'h0, exp});
  endtask
  // wait for the rail to reach a level, then judge the elapsed cycles
  task automatic rail_wait(input logic exp, input int lo, input int hi);
    int n;
    n = 0;
    while (rail_enable !== exp && n < hi) begin
      @(posedge clock);
      n++;
    end
    chk("rail", rail_enable, exp);
    chk("rail early", n >= lo, 1'b1);
  endtask
  function automatic logic [8:0] entry_ma(input logic [2:0] c);
    return (c < 4) ? 9'h032 + 9'h019 * c : 9'h0af + 9'h032 * (c - 3'h4);
  endfunction
  function automatic logic [8:0] exit_ma(input logic [2:0] c);
    return (c < 4) ? 9'h064 + 9'h019 * c : 9'h0e1 + 9'h032 * (c - 3'h4);
  endfunction
  task automatic final_report;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #(25 * 20000);
    n_errors++;
    final_report();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    pin = 1'b0;
    sleep_pin = 1'b0;
    faults = '0;
    r = $urandom(78);
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(CCR_IDX_FLAGS, 8'h00);
    rd(CCR_IDX_MASK, 8'hf8);
    rd(CCR_IDX_MISC, 8'h01);
    rd(CCR_IDX_SRST, 8'h00);
    rd(CCR_IDX_LEVEL, 8'h05);
    host_i.xfer(1'b1, CCR_IDX_ID, 8'h55);
    rd(CCR_IDX_ID, ID_VAL);
    host_i.xfer(1'b0, 8'h13, 8'h00);
    chk("unmapped err", host_i.rerr, 1'b1);
    // random config, mask and sleep pin
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      host_i.xfer(1'b1, CCR_IDX_MISC, r[7:0]);
      host_i.xfer(1'b1, CCR_IDX_MASK, r[15:8]);
      sleep_pin <= r[16];
      rd(CCR_IDX_MISC, r[7:0]);
      rd(CCR_IDX_MASK, r[15:8]);
      chk("cfg", {cfg.spread_spectrum, cfg.feedback_amp_off,
        cfg.sleep_pin_polarity, cfg.light_load_permit},
        {r[5], r[3], r[1], r[0]});
      repeat (5) @(posedge clock);
      chk("sleep", sleep_active, r[1] ? r[16] : !r[16]);
    end
    // every entry and exit code, exit kept 50 mA above entry
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, 3'(i), 1'b0, 3'(i)};
      host_i.xfer(1'b1, CCR_IDX_LEVEL, v);
      rd(CCR_IDX_LEVEL, v);
      chk("entry", cfg.entry_ma, entry_ma(v[6:4]));
      chk("exit", cfg.exit_ma, exit_ma(v[2:0]));
      chk("levels", {cfg.light_load_entry_level,
        cfg.light_load_exit_level}, {v[6:4], v[2:0]});
    end
    // each fault source, masked then unmasked, then cleared
    for (int i = 0; i < 3; i++) begin
      host_i.xfer(1'b1, CCR_IDX_MASK, 8'hf8 | (8'h01 << i));
      faults <= 3'h1 << i;
      repeat (8) @(posedge clock);
      chk("irq masked", irq_n, 1'b1);
      host_i.xfer(1'b1, CCR_IDX_MASK, 8'hf8);
      repeat (3) @(posedge clock);
      chk("irq", irq_n, 1'b0);
      host_i.xfer(1'b1, CCR_IDX_FLAGS, 8'h00);
      rd(CCR_IDX_FLAGS, 8'h01 << i);
      faults <= '0;
      repeat (4) @(posedge clock);
      rd(CCR_IDX_FLAGS, 8'h01 << i);
      host_i.xfer(1'b1, CCR_IDX_FLAGS, 8'h00);
      repeat (3) @(posedge clock);
      chk("irq clear", irq_n, 1'b1);
    end
    // rail sequencing
    host_i.xfer(1'b1, CCR_IDX_DELAY, 8'h03);
    pin <= 1'b1;
    rail_wait(1'b1, 12, 20);
    pin <= 1'b0;
    rail_wait(1'b0, 12, 20);
    pin <= 1'b1;
    repeat (6) @(posedge clock);
    pin <= 1'b0;
    repeat (30) @(posedge clock);
    chk("rail restart", rail_enable, 1'b0);
    host_i.xfer(1'b1, CCR_IDX_DELAY, 8'h00);
    pin <= 1'b1;
    rail_wait(1'b1, 0, 8);
    host_i.xfer(1'b1, CCR_IDX_DELAY, 8'hff);
    repeat (2) @(posedge clock);
    chk("rail ff", rail_enable, 1'b0);
    pin <= 1'b0;
    repeat (10) @(posedge clock);
    pin <= 1'b1;
    repeat (40) @(posedge clock);
    chk("rail never", rail_enable, 1'b0);
    pin <= 1'b0;
    host_i.xfer(1'b1, CCR_IDX_DELAY, 8'h00);
    repeat (10) @(posedge clock);
    pin <= 1'b1;
    rail_wait(1'b1, 0, 8);
    // soft restore with a live fault and a running rail
    faults <= 3'h4;
    host_i.xfer(1'b1, CCR_IDX_MISC, 8'hea);
    host_i.xfer(1'b1, CCR_IDX_LEVEL, 8'h36);
    host_i.xfer(1'b1, CCR_IDX_MASK, 8'h07);
    host_i.xfer(1'b1, CCR_IDX_DELAY, 8'h05);
    host_i.xfer(1'b1, CCR_IDX_SRST, 8'h01);
    host_i.xfer(1'b1, CCR_IDX_SRST, 8'h00);
    rd(CCR_IDX_MISC, 8'h01);
    rd(CCR_IDX_LEVEL, 8'h05);
    rd(CCR_IDX_MASK, 8'hf8);
    rd(CCR_IDX_DELAY, 8'h00);
    rd(CCR_IDX_SRST, 8'h00);
    rd(CCR_IDX_FLAGS, 8'h04);
    chk("irq restore", irq_n, 1'b0);
    chk("rail kept", rail_enable, 1'b1);
    // power-on reset in mid-run clears the flags
    faults <= '0;
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(CCR_IDX_FLAGS, 8'h00);
    chk("irq reset", irq_n, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire

// File: hdl/ccr_pkg.sv
package ccr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CCR_IDX_FLAGS = 8'h0e;
  localparam logic [7:0] CCR_IDX_MASK = 8'h0f;
  localparam logic [7:0] CCR_IDX_MISC = 8'h10;
  localparam logic [7:0] CCR_IDX_SRST = 8'h11;
  localparam logic [7:0] CCR_IDX_DELAY = 8'h12;
  localparam logic [7:0] CCR_IDX_ID = 8'h18;
  localparam logic [7:0] CCR_IDX_LEVEL = 8'h19;

  // field positions
  localparam int CCR_BIT_PG = 2;
  localparam int CCR_BIT_OVP = 1;
  localparam int CCR_BIT_SCP = 0;
  localparam int CCR_BIT_SPREAD = 5;
  localparam int CCR_BIT_AMP_OFF = 3;
  localparam int CCR_BIT_SLEEP_PIN_POLARITY = 1;
  localparam int CCR_BIT_LP = 0;
  localparam int CCR_BIT_RESTORE = 0;
  localparam int CCR_ENTRY_LSB = 4;
  localparam int CCR_EXIT_LSB = 0;

  // reset values
  localparam logic [7:0] CCR_MASK_RST = 8'hf8;
  localparam logic [7:0] CCR_MISC_RST = 8'h01;
  localparam logic [7:0] CCR_SRST_RST = 8'h00;
  localparam logic [7:0] CCR_DELAY_RST = 8'h00;
  localparam logic [7:0] CCR_LEVEL_RST = 8'h05;
  localparam logic [7:0] CCR_DELAY_NEVER = 8'hff;
  localparam logic [2:0] CCR_FLAGS_MASK = 3'h7;

  // delay step timing
  localparam int CCR_CLK_KHZ = 40000;
  localparam int CCR_STEP_US = 100;
  localparam int CCR_STEP_CYCLES = (CCR_STEP_US * CCR_CLK_KHZ) / 1000;

  // light-load current tables in mA, indexed by code
  localparam logic [8:0] CCR_ENTRY_MA [8] =
    '{9'd50, 9'd75, 9'd100, 9'd125, 9'd175, 9'd225, 9'd275, 9'd325};
  localparam logic [8:0] CCR_EXIT_MA [8] =
    '{9'd100, 9'd125, 9'd150, 9'd175, 9'd225, 9'd275, 9'd325, 9'd375};

  // fault conditions from the power stage
  typedef struct packed {
    logic power_fault;
    logic overvoltage;
    logic short_circuit;
  } ccr_fault_t;

  // configuration seen by the converter
  typedef struct packed {
    logic spread_spectrum;
    logic feedback_amp_off;
    logic sleep_pin_polarity;
    logic light_load_permit;
    logic [2:0] light_load_entry_level;
    logic [2:0] light_load_exit_level;
    logic [8:0] entry_ma;
    logic [8:0] exit_ma;
  } ccr_cfg_t;

endpackage

// File: hdl/ccr_regs.sv
// Operation
// - mask bit 2 set keeps power-fault flag off the interrupt; clear lets it on.
// - mask bit 1 set keeps overvoltage flag off the interrupt; clear lets it on.
// - mask bit 0 set keeps short-circuit flag off the interrupt; clear lets it on.
// - mask bits 7:3 are read-write and reset to all ones.
// - config bit 5 enables spread spectrum, reset 0.
// - config bit 3 switches the feedback amplifier off, reset 0.
// - config bit 1 picks sleep pin polarity; 1 active high, reset active low.
// - config bit 0, reset 1, permits light-load low-power mode.
// - writing restore bit 1 then 0 returns mask, config, restore, delay and level registers to defaults.
// - rail keeps regulating across a restore while the control pin stays high.
// - restore leaves every fault flag untouched; of the two resets only power-on reset clears them.
// - rail enables delay times 100 us after control pin asserts.
// - rail disables delay times 100 us after control pin deasserts.
// - delay value ff never enables the rail.
// - writing ff while the rail runs powers it down at once.
// - identity register is read-only: identity bit, fuse version, silicon revision.
// - bits 6:4 select light-load entry current 50 to 325 mA.
// - bits 2:0, reset 101, select light-load exit current 100 to 375 mA.
// - interrupt output low while any unmasked flag is set.
// - flags clear only by writing 0 or by power-on reset; a persisting fault sets them again.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ccr_regs
  import ccr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int STEP_CYCLES = CCR_STEP_CYCLES,
  parameter logic ID_DEVICE = 1'b0,    // arbitrary value
  parameter logic [4:0] ID_FUSE = 5'h0a, // arbitrary value
  parameter logic [1:0] ID_SILICON = 2'h2 // arbitrary value
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pins and power stage
  input wire logic HW_RAIL_CONTROL_PIN,
  input wire logic SLEEP_PIN,
  input wire ccr_fault_t FAULTS,
  // converter controls
  output ccr_cfg_t CFG,
  output logic RAIL_ENABLE,
  output logic SLEEP_ACTIVE,
  output logic IRQ_N
);

  // refuse parameters that the decode or the prescaler cannot serve
  if (ADDR_W < 10 || STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin : g_check
    $error("ccr_regs: unsupported parameter value");
  end


  logic [7:0] mask_reg;
  logic [7:0] misc_reg;
  logic [7:0] srst_reg;
  logic [7:0] delay_reg;
  logic [7:0] level_reg;
  logic [2:0] flags_reg;
  logic [2:0] fault_s1_reg, fault_s2_reg, fault_s3_reg;
  logic [1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic pin_stable_reg;
  logic sleep_stable_reg;
  logic pending_reg;
  logic target_reg;
  logic rail_reg;
  logic [15:0] pre_cnt_reg;
  logic [7:0] step_cnt_reg;
  logic [31:0] rdata_reg;
  logic [7:0] idx;
  logic mapped;
  logic wr;
  logic restore;
  logic pin_edge;
  logic step_tick;
  logic [2:0] fault_live;
  logic [7:0] rd_mux;

  // address decode
  assign idx = PADDR[9:2];
  always_comb begin
    case (idx)
      CCR_IDX_FLAGS, CCR_IDX_MASK, CCR_IDX_MISC, CCR_IDX_SRST,
      CCR_IDX_DELAY, CCR_IDX_ID, CCR_IDX_LEVEL: mapped = (PADDR[1:0] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end

  // zero-wait access phase, error on unmapped address
  assign PREADY = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign wr = PSEL & PENABLE & PWRITE & mapped & PSTRB[0];

  // restore fires on a 0 written over a 1 in the restore bit
  assign restore = wr && idx == CCR_IDX_SRST && srst_reg[CCR_BIT_RESTORE]
    && !PWDATA[CCR_BIT_RESTORE];

  // read mux
  always_comb begin
    case (idx)
      CCR_IDX_FLAGS: rd_mux = {5'h00, flags_reg};
      CCR_IDX_MASK: rd_mux = mask_reg;
      CCR_IDX_MISC: rd_mux = misc_reg;
      CCR_IDX_SRST: rd_mux = srst_reg;
      CCR_IDX_DELAY: rd_mux = delay_reg;
      CCR_IDX_ID: rd_mux = {ID_DEVICE, ID_FUSE, ID_SILICON};
      CCR_IDX_LEVEL: rd_mux = level_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // read data captured in the setup cycle, zero when unmapped
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_reg <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      rdata_reg <= mapped ? {24'h0, rd_mux} : 32'h0;
    end
  end
  assign PRDATA = rdata_reg;

  // interrupt mask, reserved bits kept writable
  always_ff @(posedge CLOCK) begin
    if (RST || restore) begin
      mask_reg <= CCR_MASK_RST;
    end else if (wr && idx == CCR_IDX_MASK) begin
      mask_reg <= PWDATA[7:0];
    end
  end

  // general configuration
  always_ff @(posedge CLOCK) begin
    if (RST || restore) begin
      misc_reg <= CCR_MISC_RST;
    end else if (wr && idx == CCR_IDX_MISC) begin
      misc_reg <= PWDATA[7:0];
    end
  end

  // restore control
  always_ff @(posedge CLOCK) begin
    if (RST || restore) begin
      srst_reg <= CCR_SRST_RST;
    end else if (wr && idx == CCR_IDX_SRST) begin
      srst_reg <= PWDATA[7:0];
    end
  end

  // rail delay and light-load levels
  always_ff @(posedge CLOCK) begin
    if (RST || restore) begin
      delay_reg <= CCR_DELAY_RST;
      level_reg <= CCR_LEVEL_RST;
    end else begin
      if (wr && idx == CCR_IDX_DELAY) begin
        delay_reg <= PWDATA[7:0];
      end
      if (wr && idx == CCR_IDX_LEVEL) begin
        level_reg <= PWDATA[7:0];
      end
    end
  end

  // fault synchronisers; a fault counts while stages two and three both hold it
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      fault_s1_reg <= 3'h0;
      fault_s2_reg <= 3'h0;
      fault_s3_reg <= 3'h0;
    end else begin
      fault_s1_reg <= FAULTS;
      fault_s2_reg <= fault_s1_reg;
      fault_s3_reg <= fault_s2_reg;
    end
  end
  assign fault_live = fault_s2_reg & fault_s3_reg;

  // sticky flags, set wins over a write of 0; restore leaves them alone
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      flags_reg <= 3'h0;
    end else if (wr && idx == CCR_IDX_FLAGS) begin
      flags_reg <= (flags_reg & PWDATA[2:0]) | fault_live;
    end else begin
      flags_reg <= flags_reg | fault_live;
    end
  end

  // interrupt, low while any unmasked flag is set
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      IRQ_N <= 1'b1;
    end else begin
      IRQ_N <= ~|(flags_reg & ~mask_reg[2:0]);
    end
  end

  // pin synchronisers: bit 0 rail control, bit 1 sleep
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pin_s1_reg <= 2'h0;
      pin_s2_reg <= 2'h0;
      pin_s3_reg <= 2'h0;
      pin_stable_reg <= 1'b0;
      sleep_stable_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {SLEEP_PIN, HW_RAIL_CONTROL_PIN};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (pin_s2_reg[0] == pin_s3_reg[0]) begin
        pin_stable_reg <= pin_s3_reg[0];
      end
      if (pin_s2_reg[1] == pin_s3_reg[1]) begin
        sleep_stable_reg <= pin_s3_reg[1];
      end
    end
  end
  assign pin_edge = (pin_s2_reg[0] == pin_s3_reg[0])
    && (pin_s3_reg[0] != pin_stable_reg);

  // prescaler for 100 us steps, restarted on each pin edge
  assign step_tick = (pre_cnt_reg == 16'(STEP_CYCLES - 1));
  always_ff @(posedge CLOCK) begin
    if (RST || pin_edge || step_tick) begin
      pre_cnt_reg <= 16'h0;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 16'h1;
    end
  end

  // step counter and pending change; restore does not touch the rail
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pending_reg <= 1'b0;
      target_reg <= 1'b0;
      step_cnt_reg <= 8'h0;
    end else if (pin_edge) begin
      pending_reg <= 1'b1;
      target_reg <= pin_s3_reg[0];
      step_cnt_reg <= 8'h0;
    end else if (pending_reg && step_cnt_reg == delay_reg) begin
      pending_reg <= 1'b0;
    end else if (pending_reg && step_tick) begin
      step_cnt_reg <= step_cnt_reg + 8'h1;
    end
  end

  // rail state
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rail_reg <= 1'b0;
    end else if (delay_reg == CCR_DELAY_NEVER) begin
      rail_reg <= 1'b0;
    end else if (pending_reg && step_cnt_reg == delay_reg) begin
      rail_reg <= target_reg;
    end
  end
  assign RAIL_ENABLE = rail_reg;

  // sleep request after polarity select
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SLEEP_ACTIVE <= 1'b0;
    end else begin
      SLEEP_ACTIVE <= misc_reg[CCR_BIT_SLEEP_PIN_POLARITY] ? sleep_stable_reg
        : ~sleep_stable_reg;
    end
  end

  // converter configuration outputs
  always_comb begin
    CFG.spread_spectrum = misc_reg[CCR_BIT_SPREAD];
    CFG.feedback_amp_off = misc_reg[CCR_BIT_AMP_OFF];
    CFG.sleep_pin_polarity = misc_reg[CCR_BIT_SLEEP_PIN_POLARITY];
    CFG.light_load_permit = misc_reg[CCR_BIT_LP];
    CFG.light_load_entry_level = level_reg[CCR_ENTRY_LSB +: 3];
    CFG.light_load_exit_level = level_reg[CCR_EXIT_LSB +: 3];
    CFG.entry_ma = CCR_ENTRY_MA[level_reg[CCR_ENTRY_LSB +: 3]];
    CFG.exit_ma = CCR_EXIT_MA[level_reg[CCR_EXIT_LSB +: 3]];
  end

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  property p_irq_pg;
    flags_reg[CCR_BIT_PG] && !mask_reg[CCR_BIT_PG] |=> !IRQ_N;
  endproperty
  a_irq_pg: assert property (p_irq_pg)
    else $error("power fault flag did not raise interrupt");

  property p_irq_ovp;
    flags_reg[CCR_BIT_OVP] && !mask_reg[CCR_BIT_OVP] |=> !IRQ_N;
  endproperty
  a_irq_ovp: assert property (p_irq_ovp)
    else $error("overvoltage flag did not raise interrupt");

  property p_irq_scp;
    flags_reg[CCR_BIT_SCP] && !mask_reg[CCR_BIT_SCP] |=> !IRQ_N;
  endproperty
  a_irq_scp: assert property (p_irq_scp)
    else $error("short circuit flag did not raise interrupt");

  property p_irq_release;
    (flags_reg & ~mask_reg[2:0]) == 3'h0 |=> IRQ_N;
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("interrupt held with no unmasked flag");

  property p_mask_reset;
    $fell(RST) |-> mask_reg == CCR_MASK_RST && misc_reg == CCR_MISC_RST;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask or config reset value wrong");

  property p_restore;
    restore |=> misc_reg == CCR_MISC_RST && delay_reg == CCR_DELAY_RST
      && level_reg == CCR_LEVEL_RST && CFG.light_load_permit;
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore did not return defaults");

  property p_flags_keep;
    restore |=> (flags_reg & $past(flags_reg)) == $past(flags_reg);
  endproperty
  a_flags_keep: assert property (p_flags_keep)
    else $error("restore cleared a fault flag");

  property p_never;
    delay_reg == CCR_DELAY_NEVER |=> !RAIL_ENABLE;
  endproperty
  a_never: assert property (p_never)
    else $error("rail enabled with delay ff");

  property p_rail_on;
    $rose(RAIL_ENABLE) |-> $past(pending_reg) && $past(target_reg)
      && $past(step_cnt_reg) == $past(delay_reg);
  endproperty
  a_rail_on: assert property (p_rail_on)
    else $error("rail enabled before its delay");

  property p_rail_off;
    $fell(RAIL_ENABLE) && $past(delay_reg) != CCR_DELAY_NEVER |->
      $past(pending_reg) && !$past(target_reg);
  endproperty
  a_rail_off: assert property (p_rail_off)
    else $error("rail disabled without pin release");

  property p_flag_sets;
    fault_live[CCR_BIT_SCP] |=> flags_reg[CCR_BIT_SCP];
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("persisting fault did not set its flag");

  c_rail_on: cover property ($rose(RAIL_ENABLE));
  c_restore: cover property (restore);
  c_irq: cover property ($fell(IRQ_N));
  c_kill: cover property (RAIL_ENABLE ##1 delay_reg == CCR_DELAY_NEVER);

endmodule
`default_nettype wire
